// >>> include/spi_stat_pkg.sv
// Purpose: Constants for the serial status and buffer interrupt block
// Assumes: 40 MHz aclk, AXI4-Lite register access
// Notes:   Offsets are byte addresses on the register bus
package spi_stat_pkg;
   localparam int          DATA_W      = 16;
   localparam int          FIFO_DEPTH  = 4;
   localparam int          CNT_W       = 3;
   localparam logic [7:0]  ADDR_STAT   = 8'h00;
   localparam logic [7:0]  ADDR_DATA   = 8'h04;
   localparam logic [7:0]  ADDR_CTRL   = 8'h08;
   localparam logic [7:0]  ADDR_IRQST  = 8'h0c;
   localparam logic [7:0]  ADDR_IRQMSK = 8'h10;
   localparam int          BIT_ON      = 15;
   localparam int          BIT_IDLE    = 13;
   localparam int          BEC_HI      = 10;
   localparam int          BEC_LO      = 8;
   localparam int          BIT_SRMT    = 7;
   localparam int          BIT_ROV     = 6;
   localparam int          BIT_RXMT    = 5;
   localparam int          SEL_HI      = 4;
   localparam int          SEL_LO      = 2;
   localparam int          BIT_TBF     = 1;
   localparam int          BIT_RBF     = 0;
   localparam int          CTRL_MASTER = 0;
   localparam int          CTRL_ENH    = 1;
   localparam int          CTRL_IDLE   = 2;
   localparam int          IRQ_W       = 2;
   localparam int          IRQ_BUF     = 0;
   localparam int          IRQ_OVF     = 1;
   localparam logic [2:0]  SEL_TXFULL  = 3'h7;
   localparam logic [2:0]  SEL_TXMT    = 3'h6;
   localparam logic [2:0]  SEL_DONE    = 3'h5;
   localparam logic [2:0]  SEL_TXOPEN  = 3'h4;
   localparam logic [2:0]  SEL_RXFULL  = 3'h3;
   localparam logic [2:0]  SEL_RX34    = 3'h2;
   localparam logic [2:0]  SEL_RXAVL   = 3'h1;
   localparam logic [2:0]  SEL_RXREAD  = 3'h0;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      SH_IDLE = 2'b00,
      SH_LOAD = 2'b01,
      SH_RUN  = 2'b11
   } shift_state_e;
endpackage

// >>> rtl/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous level input
// Notes:   Output changes when stages two and three agree
`timescale 1ns/1ps
module pin_sync (
   input  wire logic aclk,     // Block clock
   input  wire logic aresetn,  // Sync reset, active low
   input  wire logic din,      // Raw pin level
   output logic      dout      // Filtered level
);
   logic [2:0] s_q;
   logic       o_q;
   logic       o_d;

   // Output follows only when stages agree
   always_comb begin
      o_d = (s_q[1] == s_q[2]) ? s_q[2] : o_q;
   end

   // Stage one feeds only stage two
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= 3'h0;
         o_q <= 1'b0;
      end else begin
         s_q <= {s_q[1:0], din};
         o_q <= o_d;
      end
   end

   assign dout = o_q;
endmodule // pin_sync

// >>> rtl/rx_fifo_mem.sv
// Purpose: Small receive word store with registered read
// Assumes: Pointers managed by the owner
// Notes:   Read data lag the address by one cycle
`timescale 1ns/1ps
module rx_fifo_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4,
   parameter int AW    = 2
) (
   input  wire logic             aclk,   // Block clock
   input  wire logic             wr_en,  // Write strobe
   input  wire logic [AW-1:0]    wr_adr, // Write address
   input  wire logic [WIDTH-1:0] wr_dat, // Write data
   input  wire logic [AW-1:0]    rd_adr, // Read address
   output logic      [WIDTH-1:0] rd_dat  // Registered read data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] rd_q;

   // Storage holds no reset; contents are qualified by count
   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem_q[wr_adr] <= wr_dat;
      end
      rd_q <= mem_q[rd_adr];
   end

   assign rd_dat = rd_q;
endmodule // rx_fifo_mem

// >>> rtl/spi_status_and_buffer_irq.sv
// Purpose: Serial status/control, receive store and buffer interrupt
// Assumes: Link clock slower than aclk/4; one word per frame
// Notes:   Shifter is a simple mode-0 engine; TX words load by bus
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Enable bit 15 gives pins to port; clock and data drive only in master mode
// - Bit 13 halts module while idle
// - Bits 10-8 count pending or unread
// - Bit 7 set when shifter empty
// - Unread full buffer drops word, flags overflow
// - Overflow cleared by software; full flags hardware
// - Bit 5 set when receive store empty
// - Bits 4-2 pick irq, enhanced only
// - 111 irq when transmit full
// - 110 irq when transmit store empties
// - 101 irq when transfer completes
// - 100 irq when transmit slot frees
// - 011 irq when receive full
// - 010 irq at three quarters full
// - 001 irq while data available
// - 000 irq when last word read
// - Bits 14,12,11 read zero
module spi_status_and_buffer_irq import spi_stat_pkg::*; #(
   parameter int W     = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic        aclk,          // Block clock
   input  wire logic        aresetn,       // Sync reset, active low
   input  wire logic [7:0]  s_awaddr,      // Write address
   input  wire logic        s_awvalid,     // Write address valid
   output logic             s_awready,     // Write address ready
   input  wire logic [31:0] s_wdata,       // Write data
   input  wire logic [3:0]  s_wstrb,       // Write strobes
   input  wire logic        s_wvalid,      // Write data valid
   output logic             s_wready,      // Write data ready
   output logic [1:0]       s_bresp,       // Write response
   output logic             s_bvalid,      // Write response valid
   input  wire logic        s_bready,      // Write response ready
   input  wire logic [7:0]  s_araddr,      // Read address
   input  wire logic        s_arvalid,     // Read address valid
   output logic             s_arready,     // Read address ready
   output logic [31:0]      s_rdata,       // Read data
   output logic [1:0]       s_rresp,       // Read response
   output logic             s_rvalid,      // Read data valid
   input  wire logic        s_rready,      // Read data ready
   input  wire logic        idle_mode,     // Device in idle mode
   input  wire logic        sck_in,        // Serial clock pin in
   input  wire logic        sdi_in,        // Serial data pin in
   input  wire logic        ss_n_in,       // Select pin in, active low
   output logic             sck_out,       // Serial clock pin out
   output logic             sck_oe,        // Serial clock drive enable
   output logic             sdo_out,       // Serial data out
   output logic             sdo_oe,        // Serial data drive enable
   output logic             irq            // Interrupt request level
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [CNT_W:0] DEPTH_C = (CNT_W+1)'(DEPTH);
   localparam logic [CNT_W:0] THREEQ  = (CNT_W+1)'((3*DEPTH+3)/4);
   localparam logic [4:0]     BITS_C  = 5'(W);

   // Software control state
   logic             on_q, on_d, idle_sel_q, idle_sel_d;
   logic [2:0]       sel_q, sel_d;
   logic             master_q, master_d, enh_q, enh_d;
   logic             rov_q, rov_d;
   logic [IRQ_W-1:0] ist_q, ist_d, imsk_q, imsk_d;
   // Transmit holding and shifter
   logic [W-1:0]     tx_q, tx_d, sh_q, sh_d;
   logic             txf_q, txf_d;
   shift_state_e     st_q, st_d;
   logic [4:0]       bit_q, bit_d;
   logic [3:0]       div_q, div_d;
   logic             sck_q, sck_d, sdo_q, sdo_d;
   // Receive store
   logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
   logic [CNT_W:0]   cnt_q, cnt_d;
   logic [W-1:0]     rd_dat;
   logic             push;
   // Bus
   logic             awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
   logic [1:0]       br_q, br_d, rr_q, rr_d;
   logic             arr_q, arr_d, rv_q, rv_d, rpend_q, rpend_d;
   logic [31:0]      rdat_q, rdat_d;
   logic [7:0]       rad_q, rad_d;
   logic             irq_q, irq_d, oe_q, oe_d;
   logic             sck_s, sdi_s, ss_s, sck_p_q;
   logic             run, wr_go, rd_go, data_rd;
   logic             ev_done, ev_load, ev_rxrd, cond;
   logic [15:0]      stat;

   pin_sync u_sck (.aclk(aclk), .aresetn(aresetn), .din(sck_in),
      .dout(sck_s));
   pin_sync u_sdi (.aclk(aclk), .aresetn(aresetn), .din(sdi_in),
      .dout(sdi_s));
   pin_sync u_ss  (.aclk(aclk), .aresetn(aresetn), .din(ss_n_in),
      .dout(ss_s));

   rx_fifo_mem #(.WIDTH(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .aclk(aclk), .wr_en(push), .wr_adr(wp_q), .wr_dat(sh_q),
      .rd_adr(rp_q), .rd_dat(rd_dat));

   // Module runs when on and not halted by idle
   assign run = on_q && !(idle_sel_q && idle_mode);

   // Status word; unimplemented bits held at zero
   always_comb begin
      stat = 16'h0000;
      stat[BIT_ON] = on_q;
      stat[BIT_IDLE] = idle_sel_q;
      stat[BEC_HI:BEC_LO] = master_q ? {2'b00, txf_q} +
         CNT_W'(st_q != SH_IDLE) : cnt_q[CNT_W-1:0];
      stat[BIT_SRMT] = (st_q == SH_IDLE);
      stat[BIT_ROV] = rov_q;
      stat[BIT_RXMT] = (cnt_q == '0);
      stat[SEL_HI:SEL_LO] = sel_q;
      stat[BIT_TBF] = txf_q;
      stat[BIT_RBF] = (cnt_q == DEPTH_C);
   end

   assign wr_go = awr_q && wr_q;
   assign rd_go = rpend_q && !rv_q;
   assign data_rd = rd_go && (rad_q == ADDR_DATA) && (cnt_q != '0);
   // A completed word lands only if the store has room
   assign push = ev_done && (cnt_q != DEPTH_C);

   // Shifter: master drives divided clock, slave follows pin edges
   always_comb begin
      st_d = st_q; sh_d = sh_q; bit_d = bit_q; div_d = div_q;
      sck_d = sck_q; sdo_d = sdo_q; ev_done = 1'b0; ev_load = 1'b0;
      case (st_q)
         SH_IDLE: begin
            // A selected slave shifts in even with nothing to send
            if (run && (master_q ? txf_q : !ss_s)) begin
               st_d = SH_LOAD; sh_d = tx_q; ev_load = txf_q;
            end
         end
         SH_LOAD: begin
            st_d = SH_RUN; bit_d = '0; div_d = '0;
            sdo_d = sh_q[W-1];
         end
         SH_RUN: begin
            if (!run || (!master_q && ss_s)) begin // Deselect cuts frame
               st_d = SH_IDLE; sck_d = 1'b0;
            end else if (master_q) begin
               div_d = div_q + 4'h1;
               if (div_q == 4'hf) begin
                  sck_d = !sck_q;
                  if (!sck_q) begin
                     sh_d = {sh_q[W-2:0], sdi_s};
                     bit_d = bit_q + 5'h1;
                  end else begin
                     sdo_d = sh_q[W-1];
                  end
               end
            end else if (sck_s && !sck_p_q) begin
               sh_d = {sh_q[W-2:0], sdi_s};
               bit_d = bit_q + 5'h1;
            end else if (!sck_s && sck_p_q) begin
               sdo_d = sh_q[W-1];
            end
            if (bit_q == BITS_C && (!master_q || !sck_q)) begin
               st_d = SH_IDLE; ev_done = 1'b1;
            end
         end
         default: st_d = SH_IDLE;
      endcase
   end

   // Buffer interrupt condition, enhanced mode only
   always_comb begin
      case (sel_q)
         SEL_TXFULL: cond = txf_q;
         SEL_TXMT:   cond = ev_load;
         SEL_DONE:   cond = ev_done;
         SEL_TXOPEN: cond = ev_load;
         SEL_RXFULL: cond = (cnt_q == DEPTH_C);
         SEL_RX34:   cond = (cnt_q >= THREEQ);
         SEL_RXAVL:  cond = (cnt_q != '0);
         SEL_RXREAD: cond = ev_rxrd;
         default:    cond = 1'b0;
      endcase
      cond = cond && enh_q;
   end
   assign ev_rxrd = data_rd && (cnt_q == (CNT_W+1)'(1));

   // Register, store and bus state next values
   always_comb begin
      on_d = on_q; idle_sel_d = idle_sel_q; sel_d = sel_q;
      master_d = master_q; enh_d = enh_q; imsk_d = imsk_q;
      tx_d = tx_q; txf_d = txf_q; rov_d = rov_q; ist_d = ist_q;
      wp_d = wp_q; rp_d = rp_q; cnt_d = cnt_q;
      awr_d = awr_q; wr_d = wr_q; bv_d = bv_q; br_d = br_q;
      arr_d = arr_q; rv_d = rv_q; rr_d = rr_q; rpend_d = rpend_q;
      rdat_d = rdat_q; rad_d = rad_q;
      if (s_awvalid && !awr_q && !bv_q) awr_d = 1'b1;
      if (s_wvalid && !wr_q && !bv_q) wr_d = 1'b1;
      if (ev_load) txf_d = 1'b0;
      if (wr_go) begin
         awr_d = 1'b0; wr_d = 1'b0; bv_d = 1'b1; br_d = RESP_OKAY;
         case (s_awaddr)
            ADDR_STAT: begin
               if (s_wstrb[1]) begin
                  on_d = s_wdata[BIT_ON]; idle_sel_d = s_wdata[BIT_IDLE];
               end
               if (s_wstrb[0]) begin
                  sel_d = s_wdata[SEL_HI:SEL_LO];
                  if (!s_wdata[BIT_ROV]) rov_d = 1'b0;
               end
            end
            ADDR_DATA: if (!txf_q) begin
               tx_d = s_wdata[W-1:0]; txf_d = 1'b1;
            end
            ADDR_CTRL: begin
               master_d = s_wdata[CTRL_MASTER];
               enh_d = s_wdata[CTRL_ENH];
            end
            ADDR_IRQST: ist_d = ist_q & ~s_wdata[IRQ_W-1:0];
            ADDR_IRQMSK: imsk_d = s_wdata[IRQ_W-1:0];
            default: br_d = RESP_SLVERR;
         endcase
      end
      if (bv_q && s_bready) bv_d = 1'b0;
      if (s_arvalid && !arr_q && !rpend_q) begin
         arr_d = 1'b1; rad_d = s_araddr; rpend_d = 1'b1;
      end else begin
         arr_d = 1'b0;
      end
      if (rd_go) begin
         rv_d = 1'b1; rr_d = RESP_OKAY;
         case (rad_q)
            ADDR_STAT:   rdat_d = {16'h0000, stat};
            ADDR_DATA:   rdat_d = {16'h0000, rd_dat};
            ADDR_CTRL:   rdat_d = {29'h0, idle_mode, enh_q, master_q};
            ADDR_IRQST:  rdat_d = {30'h0, ist_q};
            ADDR_IRQMSK: rdat_d = {30'h0, imsk_q};
            default: begin
               rdat_d = 32'h0; rr_d = RESP_SLVERR;
            end
         endcase
      end
      if (rv_q && s_rready) begin
         rv_d = 1'b0; rpend_d = 1'b0;
      end
      if (data_rd) rp_d = rp_q + AW'(1);
      if (push) wp_d = wp_q + AW'(1);
      cnt_d = cnt_q + (CNT_W+1)'(push) - (CNT_W+1)'(data_rd);
      // Hardware set wins over software clear
      if (ev_done && !push) rov_d = 1'b1;
      if (cond) ist_d[IRQ_BUF] = 1'b1;
      if (ev_done && !push) ist_d[IRQ_OVF] = 1'b1;
   end

   // One level output from masked sticky bits
   assign irq_d = |(ist_d & imsk_d);
   assign oe_d = on_d && master_d;

   // Register everything on the block clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_q <= 1'b0; idle_sel_q <= 1'b0; sel_q <= 3'h0;
         master_q <= 1'b0; enh_q <= 1'b0; rov_q <= 1'b0;
         ist_q <= '0; imsk_q <= '0; tx_q <= '0; txf_q <= 1'b0;
         st_q <= SH_IDLE; sh_q <= '0; bit_q <= 5'h0; div_q <= 4'h0;
         sck_q <= 1'b0; sdo_q <= 1'b0; wp_q <= '0; rp_q <= '0;
         cnt_q <= '0; awr_q <= 1'b0; wr_q <= 1'b0; bv_q <= 1'b0;
         br_q <= 2'h0; arr_q <= 1'b0; rv_q <= 1'b0; rr_q <= 2'h0;
         rpend_q <= 1'b0; rdat_q <= 32'h0; rad_q <= 8'h0;
         irq_q <= 1'b0; oe_q <= 1'b0; sck_p_q <= 1'b0;
      end else begin
         on_q <= on_d; idle_sel_q <= idle_sel_d; sel_q <= sel_d;
         master_q <= master_d; enh_q <= enh_d; rov_q <= rov_d;
         ist_q <= ist_d; imsk_q <= imsk_d; tx_q <= tx_d; txf_q <= txf_d;
         st_q <= st_d; sh_q <= sh_d; bit_q <= bit_d; div_q <= div_d;
         sck_q <= sck_d; sdo_q <= sdo_d; wp_q <= wp_d; rp_q <= rp_d;
         cnt_q <= cnt_d; awr_q <= awr_d; wr_q <= wr_d; bv_q <= bv_d;
         br_q <= br_d; arr_q <= arr_d; rv_q <= rv_d; rr_q <= rr_d;
         rpend_q <= rpend_d; rdat_q <= rdat_d; rad_q <= rad_d;
         irq_q <= irq_d; oe_q <= oe_d; sck_p_q <= sck_s;
      end
   end

   // Outputs straight from flops
   assign s_awready = awr_q;
   assign s_wready  = wr_q;
   assign s_bvalid  = bv_q;
   assign s_bresp   = br_q;
   assign s_arready = arr_q;
   assign s_rvalid  = rv_q;
   assign s_rresp   = rr_q;
   assign s_rdata   = rdat_q;
   assign irq       = irq_q;
   assign sck_out   = sck_q;
   assign sck_oe    = oe_q;
   assign sdo_out   = sdo_q;
   assign sdo_oe    = oe_q;
endmodule // spi_status_and_buffer_irq

// >>> tb/spi_peer.sv
// Purpose: Far-side link partner, as master or as listener
// Assumes: Mode 0, 16-bit words, MSB first
// Notes:   Link clock stands still low between frames
`timescale 1ns/1ps
module spi_peer (
   input  wire logic sck_out, // Block clock out
   input  wire logic sdo_out, // Block data out
   input  wire logic sck_oe,  // Block drives clock
   output logic      sck,     // Peer clock
   output logic      sdi,     // Peer data to block
   output logic      ss_n     // Peer select, active low
);
   logic [15:0] sh = 16'h0;
   logic [15:0] word = 16'h0;
   int          n_bits = 0;
   int          n_words = 0;
   initial begin
      sck = 1'h0;
      sdi = 1'h0;
      ss_n = 1'h1;
   end
   // Capture block data on the rising clock while it is master
   always @(posedge sck_out) begin
      if (sck_oe === 1'h1) begin
         sh = {sh[14:0], sdo_out};
         n_bits++;
         if (n_bits % 16 == 0) begin
            word = sh;
            n_words++;
         end
      end
   end
   // One word at 200 ns per bit
   task automatic send(input logic [15:0] w);
      ss_n = 1'h0;
      for (int i = 15; i >= 0; i--) begin
         sdi = w[i];
         #100 sck = 1'h1;
         #100 sck = 1'h0;
      end
      #100 ss_n = 1'h1;
      sdi = ~w[0]; // Deselected line must not keep its value
      #300;
   endtask
endmodule // spi_peer

// >>> tb/spi_stat_monitor.sv
// Purpose: Port-level checks of the serial status block
// Assumes: One aclk domain, sync active-low reset
// Notes:   Read address is held to judge the answer
`timescale 1ns/1ps
module spi_stat_monitor import spi_stat_pkg::*; (
   input wire logic        aclk,      // Clock
   input wire logic        aresetn,   // Reset, active low
   input wire logic        s_awvalid, // AW valid
   input wire logic        s_awready, // AW ready
   input wire logic        s_bvalid,  // B valid
   input wire logic        s_bready,  // B ready
   input wire logic [1:0]  s_bresp,   // B response
   input wire logic [7:0]  s_araddr,  // AR address
   input wire logic        s_arvalid, // AR valid
   input wire logic        s_arready, // AR ready
   input wire logic [31:0] s_rdata,   // R data
   input wire logic [1:0]  s_rresp,   // R response
   input wire logic        s_rvalid,  // R valid
   input wire logic        s_rready,  // R ready
   input wire logic        sck_oe,    // Clock drive enable
   input wire logic        sdo_oe     // Data drive enable
);
   logic [7:0] ra_q;
   logic [7:0] ra_d;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Only one read is pending, so one held address suffices
   always_comb ra_d = (s_arvalid && s_arready) ? s_araddr : ra_q;
   always_ff @(posedge aclk) ra_q <= aresetn ? ra_d : 8'h0;
   sequence ar_taken;
      s_arvalid && s_arready;
   endsequence
   sequence r_waiting;
      s_rvalid && !s_rready;
   endsequence
   oe_pair_a: assert property (sck_oe == sdo_oe)
      else $error("pin enables disagree");
   stat_zero_a: assert property (s_rvalid && ra_q == ADDR_STAT |->
      s_rdata[31:16] == 16'h0 && !s_rdata[14] && s_rdata[12:11] == 2'h0)
      else $error("unused status bits set");
   unmapped_a: assert property (s_rvalid && ra_q > ADDR_IRQMSK |->
      s_rresp == RESP_SLVERR && s_rdata == 32'h0)
      else $error("unmapped read answered wrongly");
   read_answer_a: assert property (ar_taken |-> ##[1:3] s_rvalid)
      else $error("read answer late");
   read_hold_a: assert property (r_waiting |=>
      s_rvalid && $stable(s_rdata) && $stable(s_rresp))
      else $error("read answer changed early");
   write_answer_a: assert property (s_awvalid && s_awready |->
      ##[1:4] s_bvalid)
      else $error("write answer late");
   write_hold_a: assert property (s_bvalid && !s_bready |=>
      s_bvalid && $stable(s_bresp))
      else $error("write answer changed early");
   ready_pulse_a: assert property (s_awready |=> !s_awready)
      else $error("address ready not a pulse");
endmodule // spi_stat_monitor
bind spi_status_and_buffer_irq spi_stat_monitor u_spi_stat_monitor (
   .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid),
   .s_awready(s_awready), .s_bvalid(s_bvalid), .s_bready(s_bready),
   .s_bresp(s_bresp), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
   .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
   .s_rvalid(s_rvalid), .s_rready(s_rready), .sck_oe(sck_oe),
   .sdo_oe(sdo_oe));

// >>> tb/tb.sv
// Purpose: Self-checking bench for the serial status block
// Assumes: Peer model on the link, AXI4-Lite tasks here
// Notes:   Each scenario judges its own results
`timescale 1ns/1ps
module tb import spi_stat_pkg::*; ();
   logic        aclk = 1'h0, aresetn = 1'h0, idle_mode = 1'h0;
   logic [7:0]  s_awaddr = 8'h0, s_araddr = 8'h0;
   logic [31:0] s_wdata = 32'h0, s_rdata, d;
   logic [3:0]  s_wstrb = 4'h0;
   logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
   logic        s_arvalid = 1'h0, s_rready = 1'h0;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0]  s_bresp, s_rresp, r;
   logic        sck_out, sck_oe, sdo_out, sdo_oe, irq;
   logic        p_sck, sdi_in, ss_n_in;
   wire         sck_in = sck_oe ? sck_out : p_sck;
   int          n_errors = 0, num_checks = 0;
   logic [15:0] w [4] = '{16'ha5c3, 16'h0ff0, 16'h8001, 16'h7e7e};
   always #12.5 aclk = ~aclk;
   spi_status_and_buffer_irq u_spi_status_and_buffer_irq (
      .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready), .idle_mode(idle_mode),
      .sck_in(sck_in), .sdi_in(sdi_in), .ss_n_in(ss_n_in),
      .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
      .sdo_oe(sdo_oe), .irq(irq));
   spi_peer u_spi_peer (.sck_out(sck_out), .sdo_out(sdo_out),
      .sck_oe(sck_oe), .sck(p_sck), .sdi(sdi_in), .ss_n(ss_n_in));
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bus tasks start just after a rising edge and end on one
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_awaddr <= a;
      s_wdata <= v;
      s_wstrb <= 4'hf;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge aclk);
         if (s_awready === 1'h1) s_awvalid <= 1'h0;
         if (s_wready === 1'h1) s_wvalid <= 1'h0;
      end while (s_bvalid !== 1'h1);
      r = s_bresp;
      s_bready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic rc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, e);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_arready === 1'h1) s_arvalid <= 1'h0;
      end while (s_rvalid !== 1'h1);
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'h0;
      @(posedge aclk);
      chk(nm, e, d & m);
   endtask
   task automatic tx(input logic [15:0] v);
      u_spi_peer.send(v);
      @(posedge aclk);
   endtask
   // Waits end on the event; a hang is left to the watchdog
   task automatic wait_irq();
      while (irq !== 1'h1) @(posedge aclk);
   endtask
   task automatic wait_words(input int k);
      while (u_spi_peer.n_words < k) @(posedge aclk);
      chk("link word", {16'h0, w[k-1]}, {16'h0, u_spi_peer.word});
   endtask
   task automatic t_regs();
      rc("stat reset", ADDR_STAT, 32'hffff_f85c, 32'h0);
      wr(ADDR_STAT, 32'hfffc);
      rc("stat fields", ADDR_STAT, 32'hffff_f85c, 32'ha01c);
      chk("slave drive", 32'h0, {31'h0, sck_oe});
      rc("unmapped", 8'h20, 32'h0, 32'h0);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      wr(8'h20, 32'h0);
      chk("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      wr(ADDR_STAT, 32'h0);
   endtask
   task automatic t_slave();
      wr(ADDR_CTRL, 32'h2);
      wr(ADDR_IRQMSK, 32'h3);
      wr(ADDR_STAT, 32'ha004);
      idle_mode <= 1'h1;
      tx(16'h5a01);
      rc("idle halt", ADDR_STAT, 32'h720, 32'h20);
      idle_mode <= 1'h0;
      wr(ADDR_STAT, 32'h0004);
      wr(ADDR_STAT, 32'h8004);
      wr(ADDR_IRQST, 32'h3);
      tx(w[0]);
      chk("irq data ready", 32'h1, {31'h0, irq});
      rc("count one", ADDR_STAT, 32'h720, 32'h100);
      wr(ADDR_STAT, 32'h8008);
      wr(ADDR_IRQST, 32'h1);
      rc("under 3/4", ADDR_IRQST, 32'h1, 32'h0);
      tx(w[1]);
      tx(w[2]);
      rc("at 3/4", ADDR_IRQST, 32'h1, 32'h1);
      wr(ADDR_STAT, 32'h800c);
      wr(ADDR_IRQST, 32'h1);
      rc("not full", ADDR_IRQST, 32'h1, 32'h0);
      tx(w[3]);
      rc("full irq", ADDR_IRQST, 32'h1, 32'h1);
      rc("full stat", ADDR_STAT, 32'h761, 32'h401);
      tx(16'h1234);
      rc("overflow", ADDR_STAT, 32'h40, 32'h40);
      rc("overflow irq", ADDR_IRQST, 32'h2, 32'h2);
      wr(ADDR_STAT, 32'h800c);
      rc("overflow clear", ADDR_STAT, 32'h41, 32'h1);
      wr(ADDR_IRQMSK, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(ADDR_IRQMSK, 32'h3);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(ADDR_STAT, 32'h8000);
      wr(ADDR_IRQST, 32'h3);
      foreach (w[i]) begin
         if (i == 3) rc("not empty", ADDR_IRQST, 32'h1, 32'h0);
         rc("popped", ADDR_DATA, 32'hffff, {16'h0, w[i]});
      end
      rc("last read irq", ADDR_IRQST, 32'h1, 32'h1);
      rc("empty", ADDR_STAT, 32'h720, 32'h20);
   endtask
   task automatic t_master();
      wr(ADDR_STAT, 32'h0);
      wr(ADDR_CTRL, 32'h3);
      wr(ADDR_STAT, 32'h8014);
      wr(ADDR_IRQST, 32'h3);
      chk("master drive", 32'h1, {31'h0, sck_oe});
      wr(ADDR_DATA, {16'h0, w[0]});
      rc("not done", ADDR_IRQST, 32'h1, 32'h0);
      wait_irq();
      rc("done irq", ADDR_IRQST, 32'h1, 32'h1);
      rc("shifter empty", ADDR_STAT, 32'h80, 32'h80);
      wait_words(1);
      wr(ADDR_STAT, 32'h8010);
      wr(ADDR_IRQST, 32'h1);
      wr(ADDR_DATA, {16'h0, w[1]});
      rc("slot free", ADDR_IRQST, 32'h1, 32'h1);
      wr(ADDR_STAT, 32'h8018);
      wr(ADDR_IRQST, 32'h1);
      wr(ADDR_DATA, {16'h0, w[2]});
      rc("store held", ADDR_IRQST, 32'h1, 32'h0);
      wait_irq();
      rc("store empty", ADDR_IRQST, 32'h1, 32'h1);
      wr(ADDR_STAT, 32'h801c);
      wr(ADDR_IRQST, 32'h1);
      wr(ADDR_DATA, {16'h0, w[3]});
      rc("tx full", ADDR_STAT, 32'h2, 32'h2);
      rc("tx full irq", ADDR_IRQST, 32'h1, 32'h1);
      wait_words(4);
      rc("tx not full", ADDR_STAT, 32'h2, 32'h0);
      wr(ADDR_STAT, 32'h0);
      chk("off drive", 32'h0, {31'h0, sck_oe});
   endtask
   task automatic results();
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_regs();
      t_slave();
      t_master();
      results();
   end
   // Watchdog: the full run needs well under a millisecond
   initial begin
      #1500000;
      n_errors++;
      results();
   end
endmodule // tb
